/* verilog/pps_cfg.svh */
// constants for the power path and charge sequencer
`ifndef PPS_CFG_SVH
`define PPS_CFG_SVH
// timebase
`define PPS_CLK_KHZ       100000
`define PPS_CLK_PERIOD_NS 10
// delays in their own units
`define PPS_T_AGOOD_MS    500
`define PPS_T_SWITCH_MS   700
`define PPS_T_OVERCUR_MS  10
`define PPS_T_DEGLITCH_MS 2
`define PPS_T_DEAD_US     10
`define PPS_DEAD_CYC      (`PPS_T_DEAD_US * 1000 / `PPS_CLK_PERIOD_NS)
// register byte offsets
`define PPS_OFS_CTRL      8'h00
`define PPS_OFS_STATUS    8'h04
`define PPS_OFS_IRQ_STAT  8'h08
`define PPS_OFS_IRQ_MASK  8'h0C
`define PPS_OFS_TARGET    8'h10
// fields and reset values
`define PPS_CTRL_INHIBIT  0
`define PPS_NUM_EV        5
`define PPS_EV_AGOOD      0
`define PPS_EV_ON_AC      1
`define PPS_EV_ON_BAT     2
`define PPS_EV_CHG_ON     3
`define PPS_EV_CHG_OFF    4
`define PPS_MASK_RST      5'h00
// charge voltage figures in millivolts
`define PPS_VCELL_BASE_MV 16'h0FA0
`define PPS_VCELL_DEF_MV  16'h1068
`endif

/* verilog/pps_pkg.sv */
// types shared by the power path and charge sequencer
`default_nettype none
package pps_pkg;
  // selector states
  typedef enum logic [1:0] {
    SEL_BAT, SEL_BREAK_TO_AC, SEL_AC, SEL_BREAK_TO_BAT
  } pps_sel_e;
  // comparator and pin levels, all asynchronous to pclk
  typedef struct packed {
    logic [7:0] adjust_ratio;      // voltage_adjust_input / reference
    logic       adjust_at_reg;     // adjust tied to regulator
    logic       supply_ok;         // input_supply_node above 4 V
    logic       uvlo_ok;           // supply above undervoltage lockout
    logic       sense_above_lo;    // adapter_sense_input above 0.6 V
    logic       sense_above_hi;    // adapter_sense_input above 2.4 V
    logic       adapter_over_bat;  // adapter above battery + 185 mV
    logic       supply_over_bat;   // supply above battery + 185 mV
    logic       low_near_bat;      // adapter_sense_low within 285 mV
    logic       adapter_overvoltage;
    logic       thermal_shutdown;
    logic       temp_in_window;    // temperature_sense qualified
    logic       ratio_ref_ok;      // ratio_reference_input above 2.4 V
    logic       cells_low;         // cell select tied low
    logic       cells_high;        // cell select tied to reference
    logic       learn;
    logic       charge_enable_n;
    logic       input_current_over; // above input_limit_setting
  } pps_cmp_s;
  // drive and status outputs
  typedef struct packed {
    logic partial_bias;
    logic full_bias;
    logic gate_drive_regulator_en;
    logic input_current_monitor_valid;
    logic adapter_switch_drive;
    logic battery_switch_drive;
    logic charge_en;
    logic charge_status_valid;
    logic reduce_charge_current;
  } pps_drv_s;
endpackage : pps_pkg
`default_nettype wire

/* verilog/pps_sequencer.sv */
// power path handover, adapter grading and charge gating sequencer
//
// Function
// - Supply below 4 V keeps every function disabled except the battery switch drive.
// - Supply ok, sense below 0.6 V: partial bias, gate drive and monitor held low.
// - Sense above 0.6 V: full bias; gate regulator only if charge_enable_n low.
// - Sense above 2.4 V then 500 ms: adapter good, status valid, battery path kept.
// - Without valid adapter battery switch on, adapter switch off, except while SEL_AC waits for low sense near battery and in the 10 us break after it.
// - Charging needs every qualification condition true at once.
// - Charging also waits 700 ms plus 10 ms after detection.
// - Handover to adapter starts 700 ms after detection if supply over battery.
// - Handover: both drives off 10 us, then adapter on.
// - On removal wait for low sense near battery, adapter off, 10 us, battery on.
// - Cell select: float 2, low 3, reference 4 cells.
// - Target is cells times 4 V plus 0.512 ratio, default 4.2 V.
// - Input current over limit reduces charge current.
// - Learn keeps adapter off, battery on and charging off.
// - Charge enable input deglitched 2 ms before use.
`default_nettype none
`include "pps_cfg.svh"
module pps_sequencer
  import pps_pkg::*;
#(
  parameter int unsigned T_AGOOD_CYC = `PPS_T_AGOOD_MS * `PPS_CLK_KHZ,
  parameter int unsigned T_SWITCH_CYC = `PPS_T_SWITCH_MS * `PPS_CLK_KHZ,
  parameter int unsigned T_OVERCUR_CYC = `PPS_T_OVERCUR_MS * `PPS_CLK_KHZ,
  parameter int unsigned T_DEGLITCH_CYC = `PPS_T_DEGLITCH_MS * `PPS_CLK_KHZ
) (
  input  wire logic        pclk,                // 100 MHz timebase
  input  wire logic        presetn,             // async reset, low
  input  wire logic        psel,                // apb select
  input  wire logic        penable,             // apb access phase
  input  wire logic        pwrite,              // apb write
  input  wire logic [7:0]  paddr,               // apb byte address
  input  wire logic [31:0] pwdata,              // apb write data
  output logic      [31:0] prdata,              // apb read data
  output logic             pready,              // apb ready
  output logic             pslverr,             // unmapped address
  input  wire pps_cmp_s    cmp,                 // raw comparator levels
  output pps_drv_s         drv,                 // drives and status
  output logic             adapter_good_flag_o,  // open drain level
  output logic             adapter_good_flag_oe, // high pulls low
  output logic      [2:0]  cell_count,          // decoded cells
  output logic      [15:0] target_mv,           // charge target, mV
  output logic             irq                  // level interrupt
);
  localparam int unsigned CW = 32;
  localparam int unsigned NB = $bits(pps_cmp_s);
  localparam logic [CW-1:0] DEAD = CW'(`PPS_DEAD_CYC);
  localparam logic [CW-1:0] T_AG = CW'(T_AGOOD_CYC);
  localparam logic [CW-1:0] T_SW = CW'(T_SWITCH_CYC);
  localparam logic [CW-1:0] T_CH = CW'(T_SWITCH_CYC + T_OVERCUR_CYC);
  localparam logic [CW-1:0] T_DG = CW'(T_DEGLITCH_CYC);

  logic [NB-1:0] sync1, sync2;
  pps_cmp_s      c;
  pps_sel_e      sel;
  pps_drv_s      next_drv;
  logic [CW-1:0] det_cnt, dead_cnt, dg_cnt;
  logic          charge_enable_n_n_f, host_inhibit, adapter_det, qualify;
  logic [`PPS_NUM_EV-1:0] irq_stat, irq_mask, ev;
  logic          acc, wr, rd_stat;
  logic [31:0]   next_rdata;
  generate
    for (genvar i = 0; i < NB; i++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1[i] <= 1'b0;
          sync2[i] <= 1'b0;
        end else begin
          sync1[i] <= cmp[i];
          sync2[i] <= sync1[i];
        end
      end
    end
  endgenerate
  assign c = pps_cmp_s'(sync2);
  assign adapter_det = c.supply_ok && c.sense_above_lo && c.sense_above_hi;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charge_enable_n_n_f <= 1'b1;
      dg_cnt    <= '0;
    end else if (c.charge_enable_n == charge_enable_n_n_f) begin
      dg_cnt <= '0;
    end else if (dg_cnt >= T_DG - 1) begin
      charge_enable_n_n_f <= c.charge_enable_n;
      dg_cnt    <= '0;
    end else begin
      dg_cnt <= dg_cnt + 1'b1;
    end
  end
  // detection timer, saturates at the longest delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_cnt <= '0;
    end else if (!adapter_det) begin
      det_cnt <= '0;
    end else if (det_cnt < T_CH) begin
      det_cnt <= det_cnt + 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel      <= SEL_BAT;
      dead_cnt <= '0;
    end else begin
      dead_cnt <= '0;
      unique case (sel)
        SEL_BAT: begin
          if (adapter_det && det_cnt >= T_SW && c.supply_over_bat &&
              !c.learn) begin
            sel <= SEL_BREAK_TO_AC;
          end
        end
        SEL_BREAK_TO_AC: begin
          if (!adapter_det || c.learn) begin
            sel <= SEL_BAT;
          end else if (dead_cnt >= DEAD - 1) begin
            sel <= SEL_AC;
          end else begin
            dead_cnt <= dead_cnt + 1'b1;
          end
        end
        SEL_AC: begin
          // wait for low sense near battery
          if (!c.supply_ok || c.learn ||
              (!adapter_det && c.low_near_bat)) begin
            sel <= SEL_BREAK_TO_BAT;
          end
        end
        SEL_BREAK_TO_BAT: begin
          if (dead_cnt >= DEAD - 1) begin
            sel <= SEL_BAT;
          end else begin
            dead_cnt <= dead_cnt + 1'b1;
          end
        end
      endcase
    end
  end
  assign qualify = !charge_enable_n_n_f && c.uvlo_ok && adapter_det &&
                   c.adapter_over_bat && !c.adapter_overvoltage &&
                   !c.thermal_shutdown && c.temp_in_window &&
                   c.ratio_ref_ok && !c.learn && det_cnt >= T_CH &&
                   !host_inhibit;
  // output levels from supply grade and selector state
  always_comb begin
    next_drv = '0;
    next_drv.battery_switch_drive = 1'b1;
    if (c.supply_ok) begin
      next_drv.partial_bias = 1'b1;
      if (c.sense_above_lo) begin
        next_drv.full_bias = 1'b1;
        next_drv.gate_drive_regulator_en = !charge_enable_n_n_f;
        next_drv.input_current_monitor_valid = 1'b1;
      end
      // battery feeds system only in battery state
      next_drv.adapter_switch_drive = (sel == SEL_AC);
      next_drv.battery_switch_drive = (sel == SEL_BAT);
      next_drv.charge_en = qualify;
      next_drv.charge_status_valid = adapter_det && det_cnt >= T_AG;
      next_drv.reduce_charge_current = qualify && c.input_current_over;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv <= '0;
      drv.battery_switch_drive <= 1'b1;
    end else begin
      drv <= next_drv;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adapter_good_flag_o  <= 1'b0;
      adapter_good_flag_oe <= 1'b1;
    end else begin
      adapter_good_flag_o  <= 1'b0;
      adapter_good_flag_oe <= !(adapter_det && det_cnt >= T_AG);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_count <= 3'h2;
      target_mv  <= 16'h0000;
    end else begin
      cell_count <= c.cells_high ? 3'h4 : (c.cells_low ? 3'h3 : 3'h2);
      target_mv  <= 16'(cell_count * (c.adjust_at_reg ? `PPS_VCELL_DEF_MV :
                    `PPS_VCELL_BASE_MV + 16'({c.adjust_ratio, 1'b0})));
    end
  end
  // event detection
  assign ev[`PPS_EV_AGOOD]   = drv.charge_status_valid == 1'b0 &&
                               next_drv.charge_status_valid;
  assign ev[`PPS_EV_ON_AC]   = !drv.adapter_switch_drive &&
                               next_drv.adapter_switch_drive;
  assign ev[`PPS_EV_ON_BAT]  = !drv.battery_switch_drive &&
                               next_drv.battery_switch_drive;
  assign ev[`PPS_EV_CHG_ON]  = !drv.charge_en && next_drv.charge_en;
  assign ev[`PPS_EV_CHG_OFF] = drv.charge_en && !next_drv.charge_en;
  // apb access decode
  assign acc = psel && penable && pready;
  assign wr  = acc && pwrite;
  assign rd_stat = acc && !pwrite && paddr == `PPS_OFS_IRQ_STAT;
  // apb read data decode
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (paddr)
      `PPS_OFS_CTRL:     next_rdata[`PPS_CTRL_INHIBIT] = host_inhibit;
      `PPS_OFS_STATUS:   next_rdata = {23'h0, cell_count, sel,
                           charge_enable_n_n_f, !adapter_good_flag_oe,
                           adapter_det, drv.charge_en};
      `PPS_OFS_IRQ_STAT: next_rdata[`PPS_NUM_EV-1:0] = irq_stat;
      `PPS_OFS_IRQ_MASK: next_rdata[`PPS_NUM_EV-1:0] = irq_mask;
      `PPS_OFS_TARGET:   next_rdata[15:0] = target_mv;
      default:           next_rdata = 32'h0000_0000;
    endcase
  end
  // apb response: one wait state, then ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready &&
                 !(paddr inside {`PPS_OFS_CTRL, `PPS_OFS_STATUS,
                   `PPS_OFS_IRQ_STAT, `PPS_OFS_IRQ_MASK, `PPS_OFS_TARGET});
      if (psel && penable && !pready && !pwrite) begin
        prdata <= next_rdata;
      end
    end
  end
  // control and mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_inhibit <= 1'b0;
      irq_mask     <= `PPS_MASK_RST;
    end else if (wr && paddr == `PPS_OFS_CTRL) begin
      host_inhibit <= pwdata[`PPS_CTRL_INHIBIT];
    end else if (wr && paddr == `PPS_OFS_IRQ_MASK) begin
      irq_mask <= pwdata[`PPS_NUM_EV-1:0];
    end
  end
  // sticky status, a read clears only the bits it returned, new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
      irq      <= 1'b0;
    end else begin
      irq_stat <= (irq_stat &
                   ~(rd_stat ? prdata[`PPS_NUM_EV-1:0] : '0)) | ev;
      irq      <= |(irq_stat & irq_mask);
    end
  end

  // checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_OFF_DISABLED: assert property (
    !c.supply_ok |=> !drv.partial_bias && !drv.full_bias && !drv.charge_en)
    else $error("functions active with supply low");
  AST_PARTIAL_MON: assert property (
    c.supply_ok && !c.sense_above_lo |=>
      drv.partial_bias && !drv.input_current_monitor_valid)
    else $error("monitor valid without adapter sense");
  AST_REG_GATE: assert property (
    drv.gate_drive_regulator_en |-> $past(!charge_enable_n_n_f && c.sense_above_lo))
    else $error("regulator enabled while charge disabled");
  AST_AGOOD_TIME: assert property (
    $fell(adapter_good_flag_oe) |-> $past(det_cnt) >= T_AG)
    else $error("adapter good released early");
  AST_BAT_DEFAULT: assert property (
    sel == SEL_BAT && c.supply_ok |=>
      drv.battery_switch_drive && !drv.adapter_switch_drive)
    else $error("battery not feeding system");
  AST_CHG_QUAL: assert property (
    drv.charge_en |-> $past(qualify))
    else $error("charge enabled without qualification");
  AST_CHG_DELAY: assert property (
    $rose(drv.charge_en) |-> $past(det_cnt) >= T_CH)
    else $error("charge enabled before delay");
  AST_HANDOVER: assert property (
    sel == SEL_BAT ##1 sel == SEL_BREAK_TO_AC |->
      $past(det_cnt) >= T_SW && $past(c.supply_over_bat))
    else $error("handover started too early");
  AST_BREAK_OFF: assert property (
    sel == SEL_BREAK_TO_AC && c.supply_ok |=>
      !drv.adapter_switch_drive && !drv.battery_switch_drive)
    else $error("drives overlap in dead time");
  AST_DEAD_LEN: assert property (
    sel == SEL_BREAK_TO_BAT ##1 sel == SEL_BAT |->
      $past(dead_cnt) == DEAD - 1)
    else $error("dead time length wrong");
  AST_CELLS: assert property (
    c.cells_high |=> cell_count == 3'h4)
    else $error("cell decode wrong");
  AST_DPM: assert property (
    c.supply_ok && qualify && c.input_current_over |=>
      drv.reduce_charge_current)
    else $error("input limit not applied");
  AST_LEARN: assert property (
    c.learn |=> !drv.charge_en)
    else $error("charging during learn");
  AST_DEGLITCH: assert property (
    charge_enable_n_n_f != $past(charge_enable_n_n_f) |-> $past(dg_cnt) == T_DG - 1)
    else $error("charge enable taken before deglitch");
  AST_ABANDON: assert property (
    sel == SEL_BREAK_TO_AC && !adapter_det |=> sel == SEL_BAT)
    else $error("handover not abandoned");

  COV_ON_AC: cover property (sel == SEL_BREAK_TO_AC ##1 sel == SEL_AC);
  COV_ON_BAT: cover property (sel == SEL_BREAK_TO_BAT ##1 sel == SEL_BAT);
  COV_CHARGE: cover property ($rose(drv.charge_en));
  COV_IRQ: cover property ($rose(irq));
endmodule : pps_sequencer
`default_nettype wire

/* verif/pps_far_side.sv */
// far side model: comparator front end, flag pull-up and power switches
`default_nettype none
module pps_far_side
  import pps_pkg::*;
(
  input  wire pps_cmp_s    want,      // environment chosen by the bench
  input  wire pps_drv_s    drv,       // switch drives from the sequencer
  input  wire logic        flag_o,    // open-drain data
  input  wire logic        flag_oe,   // open-drain enable
  output var  pps_cmp_s    cmp,       // comparator levels
  output var  logic        flag_wire, // resolved adapter good line
  output var  logic [1:0]  sys_src    // {adapter on, battery on}
);
  timeunit 1ns;
  timeprecision 1ps;
  // a sense above 2.4 V is also above 0.6 V
  always_comb begin
    cmp = want;
    cmp.sense_above_lo = want.sense_above_lo | want.sense_above_hi;
  end
  // external pull-up to the host rail when released
  assign flag_wire = flag_oe ? flag_o : 1'b1;
  // which switch feeds the system
  assign sys_src = {drv.adapter_switch_drive, drv.battery_switch_drive};
endmodule : pps_far_side
`default_nettype wire

/* verif/pps_sequencer_tb_top.sv */
// self-checking bench for the power path and charge sequencer
`default_nettype none
module pps_sequencer_tb_top
  import pps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TAG = 50;
  localparam int TSW = 70;
  typedef struct {
    pps_cmp_s    c;
    logic [3:0]  msk;
    logic [3:0]  exp;
    logic [2:0]  cells;
    logic [15:0] tgt;
  } pps_row_s;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  pps_cmp_s    want;
  pps_cmp_s    cmp;
  pps_cmp_s    full;
  pps_drv_s    drv;
  logic        flag_o;
  logic        flag_oe;
  logic        flag_wire;
  logic [1:0]  sys_src;
  logic [2:0]  cell_count;
  logic [15:0] target_mv;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          bad_count;
  int          check_count;
  int          n;
  int          t;
  pps_row_s    rows[5];

  pps_sequencer #(.T_AGOOD_CYC(TAG), .T_SWITCH_CYC(TSW),
    .T_OVERCUR_CYC(10), .T_DEGLITCH_CYC(5)) pps_sequencer_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp(cmp), .drv(drv),
    .adapter_good_flag_o(flag_o), .adapter_good_flag_oe(flag_oe),
    .cell_count(cell_count), .target_mv(target_mv), .irq(irq));
  pps_far_side pps_far_side_i (
    .want(want), .drv(drv), .flag_o(flag_o), .flag_oe(flag_oe),
    .cmp(cmp), .flag_wire(flag_wire), .sys_src(sys_src));

  // 100 MHz timebase
  always #5 pclk = ~pclk;

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask : tick

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      chk("apb_ready", 32'h0, 32'h1);
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // bounded wait: 0 flag line, 1 battery drive, 2 adapter drive
  task automatic wait_for(input int sel, input logic lvl, input int lim);
    logic s;
    for (n = 1; n <= lim; n++) begin
      tick(1);
      s = (sel == 0) ? flag_wire : (sel == 1) ?
          drv.battery_switch_drive : drv.adapter_switch_drive;
      if (s === lvl) break;
    end
    if (n > lim) begin
      chk("wait_bound", 32'h0, 32'h1);
      end_sim();
    end
  endtask : wait_for

  function automatic pps_cmp_s mk(input logic sup, input logic lo,
      input logic cen, input logic cl, input logic ch, input logic areg,
      input logic [7:0] ratio);
    pps_cmp_s c;
    c = '0;
    c.supply_ok = sup;
    c.uvlo_ok = sup;
    c.sense_above_lo = lo;
    c.charge_enable_n = cen;
    c.cells_low = cl;
    c.cells_high = ch;
    c.adjust_at_reg = areg;
    c.adjust_ratio = ratio;
    return c;
  endfunction : mk

  // both switches on at once would short adapter to battery
  always @(posedge pclk) begin
    if (presetn === 1'b1 && sys_src === 2'h3) begin
      chk("break_before_make", 32'h0, 32'h1); // no overlap
    end
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    want = '0;
    bad_count = 0;
    check_count = 0;
    rows[0] = '{mk(0, 0, 1, 0, 0, 1, 8'h00), 4'hF, 4'h0, 3'h2, 16'h0000};
    rows[1] = '{mk(1, 0, 1, 0, 0, 1, 8'h00), 4'hF, 4'h8, 3'h2, 16'h20D0};
    rows[2] = '{mk(1, 1, 0, 1, 0, 1, 8'h00), 4'h7, 4'h7, 3'h3, 16'h3138};
    rows[3] = '{mk(1, 1, 1, 0, 1, 0, 8'h80), 4'h7, 4'h5, 3'h4, 16'h4280};
    rows[4] = '{mk(1, 1, 0, 0, 0, 0, 8'hFF), 4'h7, 4'h7, 3'h2, 16'h233C};
    full = mk(1, 1, 0, 0, 0, 0, 8'h00);
    full.sense_above_hi = 1'b1;
    full.adapter_over_bat = 1'b1;
    full.supply_over_bat = 1'b1;
    full.temp_in_window = 1'b1;
    full.ratio_ref_ok = 1'b1;
    tick(5);
    chk("rst_drv", drv, 32'h008); // battery path
    chk("rst_flag", flag_wire, 32'h0); // flag held low
    chk("rst_cells", cell_count, 32'h2); // float default
    @(posedge pclk);
    presetn <= 1'b1;
    // grading and cell decode table
    foreach (rows[i]) begin
      @(posedge pclk);
      want <= rows[i].c;
      tick(15);
      chk("bias", drv[8:5] & rows[i].msk, rows[i].exp); // bias
      chk("switches", drv[4:3], 32'h1); // battery path
      if (rows[i].c.supply_ok) begin
        chk("cells", cell_count, rows[i].cells); // decode
        chk("target", target_mv, rows[i].tgt); // voltage
      end
    end
    $display("test grading done");
    apb(1'b0, 8'h08, 32'h0);
    apb(1'b1, 8'h0C, 32'h1F);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_err", err, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    // insertion, adapter good and handover
    @(posedge pclk);
    want <= full;
    wait_for(0, 1'b1, 300);
    t = n;
    chk("agood_delay", t >= TAG && t <= TAG + 6, 32'h1); // delay
    chk("status_valid", drv.charge_status_valid, 32'h1); // status
    chk("still_bat", drv[4:3], 32'h1); // battery path
    chk("early_charge", drv.charge_en, 32'h0); // not yet
    wait_for(1, 1'b0, 300);
    t = t + n;
    chk("switch_delay", t >= TSW && t <= TSW + 6, 32'h1); // start
    chk("both_off", drv.adapter_switch_drive, 32'h0); // break
    wait_for(2, 1'b1, 1200);
    chk("dead_in", n >= 998 && n <= 1002, 32'h1); // dead time
    tick(20);
    chk("charge_on", drv.charge_en, 32'h1); // qualified
    chk("irq_up", irq, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk("status", rd, 32'hA7); // status word
    apb(1'b0, 8'h10, 32'h0);
    chk("target_rd", rd, 32'h1F40); // target readback
    apb(1'b0, 8'h08, 32'h0);
    chk("events", rd, 32'h0B);
    apb(1'b0, 8'h08, 32'h0);
    chk("read_clear", rd, 32'h0);
    tick(3);
    chk("irq_down", irq, 32'h0);
    @(posedge pclk);
    want.input_current_over <= 1'b1;
    tick(6);
    chk("reduce", drv.reduce_charge_current, 32'h1); // limit
    @(posedge pclk);
    want.input_current_over <= 1'b0;
    want.charge_enable_n <= 1'b1;
    repeat (2) @(posedge pclk);
    want.charge_enable_n <= 1'b0;
    tick(10);
    chk("glitch_charge", drv.charge_en, 32'h1); // pulse ignored
    apb(1'b0, 8'h08, 32'h0);
    chk("glitch_events", rd, 32'h0); // no charge drop
    apb(1'b1, 8'h00, 32'h1);
    tick(6);
    chk("inhibit", drv.charge_en, 32'h0);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h0C, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    $display("test handover done");
    // learn forces the battery path
    @(posedge pclk);
    want.learn <= 1'b1;
    wait_for(2, 1'b0, 20);
    wait_for(1, 1'b1, 1200);
    chk("learn_dead", n >= 998 && n <= 1002, 32'h1); // dead time
    tick(6);
    chk("learn_charge", drv.charge_en, 32'h0); // charge off
    chk("irq_masked", irq, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk("learn_events", rd, 32'h14);
    $display("test learn done");
    // removal waits for the low side near battery
    @(posedge pclk);
    want.learn <= 1'b0;
    wait_for(2, 1'b1, 1200);
    @(posedge pclk);
    want.sense_above_hi <= 1'b0;
    want.sense_above_lo <= 1'b0;
    want.adapter_over_bat <= 1'b0;
    tick(30);
    chk("hold_ac", drv[4:3], 32'h2); // waits
    @(posedge pclk);
    want.low_near_bat <= 1'b1;
    wait_for(2, 1'b0, 20);
    wait_for(1, 1'b1, 1200);
    chk("dead_out", n >= 998 && n <= 1002, 32'h1); // dead time
    $display("test removal done");
    // adapter lost inside the break interval
    @(posedge pclk);
    want <= full;
    wait_for(1, 1'b0, 300);
    @(posedge pclk);
    want.sense_above_hi <= 1'b0;
    wait_for(1, 1'b1, 1200);
    chk("abandon", drv.adapter_switch_drive, 32'h0); // back to battery
    chk("abandon_fast", n <= 6, 32'h1); // prompt return
    $display("test abandon done");
    end_sim();
  end
endmodule : pps_sequencer_tb_top
`default_nettype wire
